// ---- src/sat_pkg.sv ----
// Constants, types and decode helpers for the step attenuator control logic
`default_nettype none
package sat_pkg;

	// Attenuation word layout
	localparam int ATTEN_BITS     = 6;
	localparam int BIT_HALF_DB    = 0;
	localparam int BIT_1DB        = 1;
	localparam int BIT_2DB        = 2;
	localparam int BIT_4DB        = 3;
	localparam int BIT_8DB        = 4;
	localparam int BIT_16DB       = 5;

	// Power-up states selected in parallel mode
	localparam logic [5:0] ATTEN_REF  = 6'h00;
	localparam logic [5:0] PUP_8DB    = 6'h10;
	localparam logic [5:0] PUP_16DB   = 6'h20;
	localparam logic [5:0] PUP_31DB   = 6'h3e;

	// Pin synchroniser depth and the last priming count
	localparam int         SYNC_STAGES = 2;
	localparam logic [1:0] PRIME_LAST  = 2'h1;

	// Switching rate limit of the attenuator
	localparam int         CLK_FREQ_HZ       = 20000000;
	localparam int         SWITCH_RATE_HZ    = 25000;
	localparam int         SWITCH_GAP_CYCLES =
		(CLK_FREQ_HZ + SWITCH_RATE_HZ - 1) / SWITCH_RATE_HZ;
	localparam logic [9:0] GAP_CNT_MAX       = 10'(SWITCH_GAP_CYCLES);

	typedef enum logic [1:0] {
		SAT_ST_PRIME = 2'b00,
		SAT_ST_STRAP = 2'b01,
		SAT_ST_RUN   = 2'b10
	} sat_state_t;

	// Parallel-mode power-up select pair to attenuation word
	function automatic logic [5:0] pupDecode(input logic selMsb, input logic selLsb);
		logic [5:0] code;
		case ({selMsb, selLsb})
			2'b00:   code = ATTEN_REF;
			2'b01:   code = PUP_8DB;
			2'b10:   code = PUP_16DB;
			default: code = PUP_31DB;
		endcase
		return code;
	endfunction

endpackage
`default_nettype wire

// ---- src/sat_sync.sv ----
// Two-flop synchroniser for pins entering the ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module sat_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// First stage feeds only the second stage
	always_comb begin
		meta_d = pinIn;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign pinSync = sync_q;

endmodule // sat_sync
`default_nettype wire

// ---- src/sat_shift_reg.sv ----
// Six-bit serial-in parallel-out shift register, first bit ends on top
`timescale 1ns/1ps
`default_nettype none
module sat_shift_reg (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       shiftEn,
	input  wire logic       loadEn,
	input  wire logic [5:0] loadWord,
	input  wire logic       serialBit,
	output logic      [5:0] word
);

	logic [5:0] word_q;
	logic [5:0] word_d;

	always_comb begin
		word_d = word_q;
		if (loadEn) begin
			word_d = loadWord;
		end else if (shiftEn) begin
			word_d = {word_q[4:0], serialBit};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			word_q <= sat_pkg::ATTEN_REF;
		end else begin
			word_q <= word_d;
		end
	end

	assign word = word_q;

	default clocking cbShift @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_shift_move_up: assert property (
		shiftEn && !loadEn |=> word == {$past(word[4:0]), $past(serialBit)})
		else $error("shift did not move toward msb");
	chk_load_word: assert property (
		loadEn |=> word == $past(loadWord))
		else $error("preload word not taken");

endmodule // sat_shift_reg
`default_nettype wire

// ---- src/sat_step_atten_ctrl.sv ----
// Control logic of the six-bit step attenuator: serial, parallel and power-up
`timescale 1ns/1ps
`default_nettype none
module sat_step_atten_ctrl (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       modeSerial,
	input  wire logic       updateStrobe,
	input  wire logic       attenWeight16Db,
	input  wire logic       attenWeight8Db,
	input  wire logic       attenWeight4Db,
	input  wire logic       attenWeight2Db,
	input  wire logic       attenWeight1Db,
	input  wire logic       attenWeightHalfDb,
	input  wire logic       powerupSelectMsb,
	input  wire logic       powerupSelectLsb,
	input  wire logic       serialClk,
	input  wire logic       serialData,
	output logic      [5:0] attenCode,
	output logic            powerupDone,
	output logic            rateViolation
);

	// Raw pin vector, weights placed by bit position
	logic [5:0]  weightsRaw;
	logic [11:0] pinsRaw;
	logic [11:0] pinsSync;

	// Synchronised pin levels
	logic [5:0] weightsS;
	logic       modeSerialS;
	logic       strobeS;
	logic       selMsbS;
	logic       selLsbS;
	logic       serClkS;
	logic       serDataS;

	// Power-up sequencing and the attenuation latch
	sat_pkg::sat_state_t state_q;
	sat_pkg::sat_state_t state_d;
	logic [1:0]          primeCnt_q;
	logic [1:0]          primeCnt_d;
	logic [5:0]          latch_q;
	logic [5:0]          latch_d;
	logic                done_q;
	logic                done_d;

	// Serial clock edge finder
	logic serClkPrev_q;
	logic serClkPrev_d;
	logic serClkRise;
	logic shiftEn;
	logic shiftLoad;
	logic [5:0] shiftWord;

	// Switching rate monitor
	logic [9:0] gapCnt_q;
	logic [9:0] gapCnt_d;
	logic       viol_q;
	logic       viol_d;
	logic       codeChange;

	always_comb begin
		weightsRaw                       = '0;
		weightsRaw[sat_pkg::BIT_HALF_DB] = attenWeightHalfDb;
		weightsRaw[sat_pkg::BIT_1DB]     = attenWeight1Db;
		weightsRaw[sat_pkg::BIT_2DB]     = attenWeight2Db;
		weightsRaw[sat_pkg::BIT_4DB]     = attenWeight4Db;
		weightsRaw[sat_pkg::BIT_8DB]     = attenWeight8Db;
		weightsRaw[sat_pkg::BIT_16DB]    = attenWeight16Db;
		pinsRaw = {weightsRaw, modeSerial, updateStrobe, powerupSelectMsb,
			powerupSelectLsb, serialClk, serialData};
	end

	// Every pin is asynchronous to ref_clk; clock and data share one delay
	sat_sync #(
		.WIDTH (12)
	) uPinSync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pinIn   (pinsRaw),
		.pinSync (pinsSync)
	);

	always_comb begin
		weightsS    = pinsSync[11:6];
		modeSerialS = pinsSync[5];
		strobeS     = pinsSync[4];
		selMsbS     = pinsSync[3];
		selLsbS     = pinsSync[2];
		serClkS     = pinsSync[1];
		serDataS    = pinsSync[0];
	end

	// Serial clock rise found by oversampling; needs ref_clk well above it
	always_comb begin
		serClkPrev_d = serClkS;
		serClkRise   = serClkS && !serClkPrev_q;
		shiftEn      = (state_q == sat_pkg::SAT_ST_RUN) && serClkRise;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			serClkPrev_q <= 1'b0;
		end else begin
			serClkPrev_q <= serClkPrev_d;
		end
	end

	sat_shift_reg uShift (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.shiftEn   (shiftEn),
		.loadEn    (shiftLoad),
		.loadWord  (weightsS),
		.serialBit (serDataS),
		.word      (shiftWord)
	);

	// Straps are only trusted once the synchronisers have filled
	always_comb begin
		state_d    = state_q;
		primeCnt_d = primeCnt_q;
		latch_d    = latch_q;
		done_d     = done_q;
		shiftLoad  = 1'b0;
		case (state_q)
			sat_pkg::SAT_ST_PRIME: begin
				if (primeCnt_q == sat_pkg::PRIME_LAST) begin
					state_d = sat_pkg::SAT_ST_STRAP;
				end else begin
					primeCnt_d = primeCnt_q + 2'h1;
				end
			end
			sat_pkg::SAT_ST_STRAP: begin
				state_d = sat_pkg::SAT_ST_RUN;
				done_d  = 1'b1;
				if (modeSerialS) begin
					// Shift word preloaded too, so an open latch shows the same value
					latch_d   = weightsS;
					shiftLoad = 1'b1;
				end else if (strobeS) begin
					latch_d = weightsS;
				end else begin
					latch_d = sat_pkg::pupDecode(selMsbS, selLsbS);
				end
			end
			sat_pkg::SAT_ST_RUN: begin
				if (strobeS) begin
					latch_d = modeSerialS ? shiftWord : weightsS;
				end
			end
			default: begin
				state_d = sat_pkg::SAT_ST_PRIME;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q    <= sat_pkg::SAT_ST_PRIME;
			primeCnt_q <= 2'h0;
			latch_q    <= sat_pkg::ATTEN_REF;
			done_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			primeCnt_q <= primeCnt_d;
			latch_q    <= latch_d;
			done_q     <= done_d;
		end
	end

	// Flags a change that follows the previous one too closely; sticky to reset
	always_comb begin
		codeChange = (state_q == sat_pkg::SAT_ST_RUN) && (latch_d != latch_q);
		viol_d     = viol_q;
		gapCnt_d   = gapCnt_q;
		if (codeChange) begin
			if (gapCnt_q < sat_pkg::GAP_CNT_MAX) begin
				viol_d = 1'b1;
			end
			gapCnt_d = 10'h000;
		end else if (gapCnt_q < sat_pkg::GAP_CNT_MAX) begin
			gapCnt_d = gapCnt_q + 10'h001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gapCnt_q <= sat_pkg::GAP_CNT_MAX;
			viol_q   <= 1'b0;
		end else begin
			gapCnt_q <= gapCnt_d;
			viol_q   <= viol_d;
		end
	end

	assign attenCode     = latch_q;
	assign powerupDone   = done_q;
	assign rateViolation = viol_q;

	// Position within the serial word, for the order check only; restarts on preload
	logic [2:0] shiftCnt_q;
	logic [2:0] shiftCnt_d;
	logic       firstBit_q;
	logic       firstBit_d;

	always_comb begin
		shiftCnt_d = shiftCnt_q;
		firstBit_d = firstBit_q;
		if (shiftLoad) begin
			shiftCnt_d = 3'h0;
		end else if (shiftEn) begin
			if (shiftCnt_q == 3'h0) begin
				firstBit_d = serDataS;
			end
			if (shiftCnt_q == 3'(sat_pkg::ATTEN_BITS - 1)) begin
				shiftCnt_d = 3'h0;
			end else begin
				shiftCnt_d = shiftCnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shiftCnt_q <= 3'h0;
			firstBit_q <= 1'b0;
		end else begin
			shiftCnt_q <= shiftCnt_d;
			firstBit_q <= firstBit_d;
		end
	end

	default clocking cbCtrl @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence sqInRun;
		state_q == sat_pkg::SAT_ST_RUN;
	endsequence

	sequence sqStrapPar;
		state_q == sat_pkg::SAT_ST_STRAP && !modeSerialS && !strobeS;
	endsequence

	property pResetRef;
		@(posedge ref_clk) disable iff (1'b0)
		rst |=> attenCode == sat_pkg::ATTEN_REF;
	endproperty

	sequence sqSixthShift;
		shiftEn && !shiftLoad && shiftCnt_q == 3'(sat_pkg::ATTEN_BITS - 1);
	endsequence

	chk_reset_ref_state: assert property (
		pResetRef)
		else $error("attenuation not reference after reset");
	chk_powerup_bound: assert property (
		$fell(rst) |-> ##2 !powerupDone ##1 powerupDone)
		else $error("power-up state not set in three cycles");
	chk_par_direct_follow: assert property (
		sqInRun ##0 (!modeSerialS && strobeS) |=> attenCode == $past(weightsS))
		else $error("direct parallel mode not following");
	chk_serial_latch_open: assert property (
		sqInRun ##0 (modeSerialS && strobeS) |=> attenCode == $past(shiftWord))
		else $error("open latch not passing shift word");
	chk_latch_hold_low: assert property (
		sqInRun ##0 !strobeS |=> $stable(attenCode))
		else $error("latch changed with strobe low");
	chk_pup_serial_load: assert property (
		state_q == sat_pkg::SAT_ST_STRAP && modeSerialS
		|=> attenCode == $past(weightsS) && shiftWord == $past(weightsS))
		else $error("serial power-up not from parallel inputs");
	chk_pup_all_high: assert property (
		sqStrapPar ##0 (selMsbS && selLsbS) |=> attenCode == 6'h3e)
		else $error("select pair both high not 31 dB");
	chk_pup_lsb_only: assert property (
		sqStrapPar ##0 (!selMsbS && selLsbS) |=> attenCode == 6'h10)
		else $error("lsb select not 8 dB");
	chk_pup_msb_only: assert property (
		sqStrapPar ##0 (selMsbS && !selLsbS) |=> attenCode == 6'h20)
		else $error("msb select not 16 dB");
	chk_pup_both_low: assert property (
		sqStrapPar ##0 (!selMsbS && !selLsbS) |=> attenCode == 6'h00)
		else $error("select pair low not reference");
	chk_pup_direct_par: assert property (
		state_q == sat_pkg::SAT_ST_STRAP && !modeSerialS && strobeS
		|=> attenCode == $past(weightsS))
		else $error("select pair not ignored with strobe high");
	chk_shift_on_rise: assert property (
		sqInRun ##0 $rose(serClkS) |=> shiftWord == {$past(shiftWord[4:0]), $past(serDataS)})
		else $error("serial rise did not shift");
	chk_first_bit_top: assert property (
		sqSixthShift |=> shiftWord[5] == firstBit_q)
		else $error("first serial bit not in top position");

endmodule // sat_step_atten_ctrl
`default_nettype wire

// ---- testbench/sat_ctrl_model.sv ----
// Behavioural external controller driving the attenuator control pins
`timescale 1ns/1ps
`default_nettype none
module sat_ctrl_model (
	input  wire logic       ref_clk,
	output logic            modeSerial,
	output logic            updateStrobe,
	output logic      [5:0] weights,
	output logic            pupMsb,
	output logic            pupLsb,
	output logic            serialClk,
	output logic            serialData
);
	initial begin
		modeSerial = 1'b0;
		updateStrobe = 1'b1;
		weights = 6'h00;
		pupMsb = 1'b0;
		pupLsb = 1'b0;
		serialClk = 1'b0;
		serialData = 1'b0;
	end

	task automatic setPins(input logic m, input logic s, input logic [5:0] w,
		input logic pm, input logic pl);
		@(posedge ref_clk);
		#5;
		modeSerial = m;
		updateStrobe = s;
		weights = w;
		pupMsb = pm;
		pupLsb = pl;
	endtask

	// Strobe held well past one sync delay so the pulse is never lost
	task automatic pulse();
		@(posedge ref_clk);
		#5;
		updateStrobe = 1'b1;
		repeat (4) @(posedge ref_clk);
		#5;
		updateStrobe = 1'b0;
	endtask

	// Clock idles low between bits; data goes stale once hold has run out
	// Back to back bits give a 400 ns serial clock period
	task automatic sendBit(input logic b);
		@(posedge ref_clk);
		#5;
		serialData = b;
		#100;
		serialClk = 1'b1;
		#200;
		serialClk = 1'b0;
		#80;
		serialData = ~b;
	endtask

	task automatic sendWord(input logic [5:0] w);
		for (int i = 5; i >= 0; i--) begin
			sendBit(w[i]);
		end
	endtask
endmodule // sat_ctrl_model
`default_nettype wire

// ---- testbench/sat_step_atten_ctrl_tb.sv ----
// Self-checking bench for the step attenuator control logic
`timescale 1ns/1ps
`default_nettype none
module sat_step_atten_ctrl_tb;
	typedef struct {logic [5:0] w; logic [5:0] exp;} sat_row_t;
	logic       ref_clk;
	logic       rst;
	logic       modeSerial;
	logic       updateStrobe;
	logic [5:0] weights;
	logic       pupMsb;
	logic       pupLsb;
	logic       serialClk;
	logic       serialData;
	logic [5:0] attenCode;
	logic       powerupDone;
	logic       rateViolation;
	int         errCount = 0;
	int         numChecks = 0;
	sat_row_t   rows [8] = '{'{6'h01, 6'h01}, '{6'h02, 6'h02}, '{6'h04, 6'h04},
		'{6'h08, 6'h08}, '{6'h10, 6'h10}, '{6'h20, 6'h20}, '{6'h3f, 6'h3f}, '{6'h00, 6'h00}};
	logic [5:0] pupExp [4] = '{6'h00, 6'h10, 6'h20, 6'h3e};
	logic [5:0] prev;

	sat_ctrl_model ctrl_u (.ref_clk(ref_clk), .modeSerial(modeSerial),
		.updateStrobe(updateStrobe), .weights(weights), .pupMsb(pupMsb), .pupLsb(pupLsb),
		.serialClk(serialClk), .serialData(serialData));

	sat_step_atten_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .modeSerial(modeSerial),
		.updateStrobe(updateStrobe), .attenWeight16Db(weights[5]),
		.attenWeight8Db(weights[4]), .attenWeight4Db(weights[3]),
		.attenWeight2Db(weights[2]), .attenWeight1Db(weights[1]),
		.attenWeightHalfDb(weights[0]), .powerupSelectMsb(pupMsb),
		.powerupSelectLsb(pupLsb), .serialClk(serialClk), .serialData(serialData),
		.attenCode(attenCode), .powerupDone(powerupDone), .rateViolation(rateViolation));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		if (errCount == 0 && numChecks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Keeps code changes under the switching rate of the attenuator
	task automatic gap();
		repeat (900) @(posedge ref_clk);
	endtask

	task automatic settle();
		repeat (6) @(posedge ref_clk);
		#1;
	endtask

	task automatic powerUp(input logic m, input logic s, input logic [5:0] w,
		input logic pm, input logic pl, input logic [5:0] exp);
		ctrl_u.setPins(m, s, w, pm, pl);
		rst = 1'b1;
		repeat (10) @(posedge ref_clk);
		#5;
		rst = 1'b0;
		settle();
		check("attenCode", attenCode, exp);
		check("powerupDone", {5'h00, powerupDone}, 6'h01);
		gap();
	endtask

	initial begin
		rst = 1'b1;
		powerUp(1'b0, 1'b1, 6'h00, 1'b0, 1'b0, 6'h00);
		prev = 6'h00;
		foreach (rows[i]) begin
			ctrl_u.setPins(1'b0, 1'b0, rows[i].w, 1'b0, 1'b0);
			settle();
			check("attenCode", attenCode, prev);
			ctrl_u.pulse();
			settle();
			check("attenCode", attenCode, rows[i].exp);
			prev = rows[i].exp;
			gap();
		end
		ctrl_u.setPins(1'b0, 1'b1, 6'h2b, 1'b0, 1'b0);
		settle();
		check("attenCode", attenCode, 6'h2b);
		gap();
		for (int i = 0; i < 4; i++) begin
			powerUp(1'b0, 1'b0, 6'h2a, i[1], i[0], pupExp[i]);
		end
		powerUp(1'b0, 1'b1, 6'h2a, 1'b1, 1'b1, 6'h2a);
		powerUp(1'b1, 1'b0, 6'h15, 1'b1, 1'b1, 6'h15);
		ctrl_u.sendWord(6'h31);
		settle();
		check("attenCode", attenCode, 6'h15);
		ctrl_u.pulse();
		settle();
		check("attenCode", attenCode, 6'h31);
		gap();
		// Open latch, one more bit goes straight through
		ctrl_u.setPins(1'b1, 1'b1, 6'h15, 1'b0, 1'b0);
		ctrl_u.sendBit(1'b1);
		settle();
		check("attenCode", attenCode, 6'h23);
		gap();
		ctrl_u.setPins(1'b1, 1'b0, 6'h15, 1'b0, 1'b0);
		ctrl_u.sendWord(6'h0c);
		settle();
		check("attenCode", attenCode, 6'h23);
		ctrl_u.setPins(1'b0, 1'b1, 6'h07, 1'b0, 1'b0);
		settle();
		check("attenCode", attenCode, 6'h07);
		check("rateViolation", {5'h00, rateViolation}, 6'h00);
		// Deliberate fast change to see the sticky flag
		ctrl_u.setPins(1'b0, 1'b1, 6'h08, 1'b0, 1'b0);
		settle();
		check("rateViolation", {5'h00, rateViolation}, 6'h01);
		results();
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		errCount++;
		results();
	end
endmodule // sat_step_atten_ctrl_tb
`default_nettype wire
